// >>> core/etac_pkg.sv
// constants and types of the exposure and timing control register bank
package etac_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_AE_EN      = 12'h150;
  localparam logic [11:0] OFS_AG_EN      = 12'h154;
  localparam logic [11:0] OFS_LUMA_TGT   = 12'h158;
  localparam logic [11:0] OFS_MAX_GAIN   = 12'h160;
  localparam logic [11:0] OFS_AE_SPEED   = 12'h174;
  localparam logic [11:0] OFS_AG_SPEED   = 12'h178;
  localparam logic [11:0] OFS_CFR        = 12'h200;
  localparam logic [11:0] OFS_W6_WIDTH   = 12'h240;
  localparam logic [11:0] OFS_W6_HOFS    = 12'h260;
  localparam logic [11:0] OFS_W6_HEIGHT  = 12'h280;
  localparam logic [11:0] OFS_W6_VOFS    = 12'h2A0;
  localparam logic [11:0] OFS_EXP_MODE   = 12'h544;
  localparam logic [11:0] OFS_EXP_TIME   = 12'h548;
  localparam logic [11:0] OFS_LINE_EXT   = 12'h54C;
  localparam logic [11:0] OFS_FRAME_EXT  = 12'h550;
  localparam logic [11:0] OFS_LINE_TIME  = 12'h554;
  localparam logic [11:0] OFS_FRAME_TIME = 12'h558;
  localparam logic [11:0] OFS_LINE_EXTNT = 12'h5A8;
  localparam logic [11:0] OFS_FRM_EXTNT  = 12'h5AC;
  localparam logic [11:0] OFS_MAX_EXP    = 12'h5B0;
  localparam logic [11:0] OFS_SPEED      = 12'h608;
  localparam logic [11:0] OFS_STATUS     = 12'h610;
  localparam logic [11:0] OFS_EXP_APPL   = 12'h614;

  // ---------------------------------------------------------------
  // field widths and reset values
  // ---------------------------------------------------------------
  localparam int WIN_W   = 12;
  localparam int LINE_W  = 13;
  localparam int TIME_W  = 24;
  localparam int GAIN_W  = 10;
  localparam int SPEED_W = 2;
  localparam logic [TIME_W-1:0] RST_MAX_EXP  = 24'hFFFFFF;
  localparam logic [GAIN_W-1:0] RST_MAX_GAIN = 10'h3FF;
  localparam logic [WIN_W-1:0]  RST_LUMA_TGT = 12'h800;
  localparam logic [TIME_W-1:0] RST_EXP_TIME = 24'h0003E8;

  // ---------------------------------------------------------------
  // timing: one microsecond in core clock cycles
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EXP_OFF,
    EXP_PULSE,
    EXP_INTERNAL,
    EXP_EXTERNAL
  } etac_exp_mode_t;

  typedef struct packed {
    logic [WIN_W-1:0] h_offset;
    logic [WIN_W-1:0] width;
    logic [WIN_W-1:0] v_offset;
    logic [WIN_W-1:0] height;
  } etac_window_t;

  typedef struct packed {
    logic              const_rate;
    logic              all_pixels;
    logic              all_lines;
    logic              fast_speed;
    logic              line_ext;
    logic              frame_ext;
    logic [LINE_W-1:0] line_time;
    logic [TIME_W-1:0] frame_time;
  } etac_timing_t;

endpackage

// >>> core/etac_regs.sv
// exposure, frame timing and auto loop control register bank on AHB-Lite
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - window six width, 12 bits at 0x240
// - window six vertical offset, 12 bits at 0x2A0
// - window six height, 12 bits at 0x280
// - bit 0 at 0x200 enables constant frame rate
// - bit 0 at 0x5A8: active pixels only or all visible pixels
// - bit 0 at 0x5AC: active lines only or all visible lines
// - 2-bit exposure mode: off, trigger width, internal timer, external
// - internal mode exposes for 24-bit microsecond time at 0x548 while auto exposure is off
// - bit 0 at 0x54C stretches every line to programmed line time
// - line time is 13 bits in pixel periods at 0x554
// - bit 0 at 0x550 extends frame time for long integration
// - frame time is 24 bits in microseconds at 0x558
// - bit 0 at 0x608 selects normal or fast speed
// - bit 0 at 0x150 enables auto exposure loop
// - auto exposure kept within 24-bit maximum at 0x5B0
// - exposure loop speed 1x to 4x from two bits at 0x174
// - bit 0 at 0x154 enables auto gain loop
// - auto gain kept within 10-bit maximum at 0x160
// - gain loop speed 1x to 4x from two bits at 0x178
// - window six horizontal offset, 12 bits at 0x260
// - both loops aim at 12-bit luminance target at 0x158
module etac_regs
  import etac_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  output logic [31:0]            o_hrdata,
  // sensor timing inputs, core clock domain
  input  wire logic              i_frame_start,
  input  wire logic              i_line_start,
  input  wire logic              i_pixel_tick,
  // exposure pins from outside
  input  wire logic              i_trigger,
  input  wire logic              i_ext_exposure,
  // auto loop requests, core clock domain
  input  wire logic [TIME_W-1:0] i_ae_exposure_req,
  input  wire logic [GAIN_W-1:0] i_ag_gain_req,
  // applied settings
  output etac_window_t           o_window6,
  output etac_timing_t           o_timing,
  output logic                   o_exposure_active,
  output logic                   o_line_hold,
  output logic                   o_frame_hold,
  output logic                   o_ae_enable,
  output logic                   o_ag_enable,
  output logic [2:0]             o_ae_step_mult,
  output logic [2:0]             o_ag_step_mult,
  output logic [WIN_W-1:0]       o_luma_target,
  output logic [GAIN_W-1:0]      o_gain_applied
);

  // ---------------------------------------------------------------
  // software-visible registers
  // ---------------------------------------------------------------
  logic                 ae_en;
  logic                 ag_en;
  logic [WIN_W-1:0]     luma_tgt;
  logic [GAIN_W-1:0]    max_gain;
  logic [SPEED_W-1:0]   ae_speed;
  logic [SPEED_W-1:0]   ag_speed;
  etac_window_t         win;
  etac_timing_t         tim;
  etac_exp_mode_t       exp_mode;
  logic [TIME_W-1:0]    exp_time;
  logic [TIME_W-1:0]    max_exp;

  // ---------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------
  logic                 wr_pend;
  logic                 rd_pend;
  logic [11:0]          bus_addr;
  logic                 bus_hit;
  logic                 addr_take;
  logic [31:0]          next_rdata;

  // ---------------------------------------------------------------
  // exposure and timing state
  // ---------------------------------------------------------------
  logic [4:0]           us_cnt;
  logic                 us_tick;
  logic [TIME_W-1:0]    exp_applied;
  logic [TIME_W-1:0]    next_exp;
  logic [TIME_W-1:0]    exp_cnt;
  logic [LINE_W-1:0]    line_cnt;
  logic [TIME_W-1:0]    frame_cnt;
  logic                 trig_s1;
  logic                 trig_s2;
  logic                 ext_s1;
  logic                 ext_s2;
  etac_exp_mode_t       mode_applied;

  // ---------------------------------------------------------------
  // ahb-lite address phase
  // ---------------------------------------------------------------
  // only word transfers; any other size is still answered okay
  assign addr_take = i_hsel & i_htrans[1] & i_hready;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      bus_addr <= 12'h000;
      bus_hit  <= 1'b0;
    end else begin
      rd_pend <= addr_take & ~i_hwrite;
      if (addr_take) begin
        wr_pend  <= i_hwrite;
        bus_addr <= {i_haddr[11:2], 2'b00};
        bus_hit  <= (i_haddr[31:12] == 20'h00000);
      end else if (o_hreadyout) begin
        wr_pend  <= 1'b0;
      end
    end
  end

  // reads take one wait state so a write just before is visible
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_hrdata    <= 32'h00000000;
    end else begin
      o_hresp <= 1'b0;
      if (addr_take && !i_hwrite) begin
        o_hreadyout <= 1'b0;
      end else if (rd_pend) begin
        o_hreadyout <= 1'b1;
        o_hrdata    <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (bus_hit) begin
      case (bus_addr)
        OFS_AE_EN:      next_rdata = {31'h0, ae_en};
        OFS_AG_EN:      next_rdata = {31'h0, ag_en};
        OFS_LUMA_TGT:   next_rdata = {20'h0, luma_tgt};
        OFS_MAX_GAIN:   next_rdata = {22'h0, max_gain};
        OFS_AE_SPEED:   next_rdata = {30'h0, ae_speed};
        OFS_AG_SPEED:   next_rdata = {30'h0, ag_speed};
        OFS_CFR:        next_rdata = {31'h0, tim.const_rate};
        OFS_W6_WIDTH:   next_rdata = {20'h0, win.width};
        OFS_W6_HOFS:    next_rdata = {20'h0, win.h_offset};
        OFS_W6_HEIGHT:  next_rdata = {20'h0, win.height};
        OFS_W6_VOFS:    next_rdata = {20'h0, win.v_offset};
        OFS_EXP_MODE:   next_rdata = {30'h0, exp_mode};
        OFS_EXP_TIME:   next_rdata = {8'h0, exp_time};
        OFS_LINE_EXT:   next_rdata = {31'h0, tim.line_ext};
        OFS_FRAME_EXT:  next_rdata = {31'h0, tim.frame_ext};
        OFS_LINE_TIME:  next_rdata = {19'h0, tim.line_time};
        OFS_FRAME_TIME: next_rdata = {8'h0, tim.frame_time};
        OFS_LINE_EXTNT: next_rdata = {31'h0, tim.all_pixels};
        OFS_FRM_EXTNT:  next_rdata = {31'h0, tim.all_lines};
        OFS_MAX_EXP:    next_rdata = {8'h0, max_exp};
        OFS_SPEED:      next_rdata = {31'h0, tim.fast_speed};
        OFS_STATUS:     next_rdata = {29'h0, o_frame_hold,
                                      o_line_hold, o_exposure_active};
        OFS_EXP_APPL:   next_rdata = {8'h0, exp_applied};
        default:        next_rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register writes, data phase
  // ---------------------------------------------------------------
  // only the documented low bits are stored; upper bits are dropped
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ae_en    <= 1'b0;
      ag_en    <= 1'b0;
      luma_tgt <= RST_LUMA_TGT;
      max_gain <= RST_MAX_GAIN;
      ae_speed <= 2'h0;
      ag_speed <= 2'h0;
      win      <= '0;
      tim      <= '0;
      exp_mode <= EXP_OFF;
      exp_time <= RST_EXP_TIME;
      max_exp  <= RST_MAX_EXP;
    end else if (wr_pend && bus_hit && o_hreadyout) begin
      case (bus_addr)
        OFS_AE_EN:      ae_en <= i_hwdata[0];
        OFS_AG_EN:      ag_en <= i_hwdata[0];
        OFS_LUMA_TGT:   luma_tgt <= i_hwdata[11:0];
        OFS_MAX_GAIN:   max_gain <= i_hwdata[9:0];
        OFS_AE_SPEED:   ae_speed <= i_hwdata[1:0];
        OFS_AG_SPEED:   ag_speed <= i_hwdata[1:0];
        OFS_CFR:        tim.const_rate <= i_hwdata[0];
        OFS_W6_WIDTH:   win.width <= i_hwdata[11:0];
        OFS_W6_HOFS:    win.h_offset <= i_hwdata[11:0];
        OFS_W6_HEIGHT:  win.height <= i_hwdata[11:0];
        OFS_W6_VOFS:    win.v_offset <= i_hwdata[11:0];
        OFS_EXP_MODE:   exp_mode <= etac_exp_mode_t'(i_hwdata[1:0]);
        OFS_EXP_TIME:   exp_time <= i_hwdata[23:0];
        OFS_LINE_EXT:   tim.line_ext <= i_hwdata[0];
        OFS_FRAME_EXT:  tim.frame_ext <= i_hwdata[0];
        OFS_LINE_TIME:  tim.line_time <= i_hwdata[12:0];
        OFS_FRAME_TIME: tim.frame_time <= i_hwdata[23:0];
        OFS_LINE_EXTNT: tim.all_pixels <= i_hwdata[0];
        OFS_FRM_EXTNT:  tim.all_lines <= i_hwdata[0];
        OFS_MAX_EXP:    max_exp <= i_hwdata[23:0];
        OFS_SPEED:      tim.fast_speed <= i_hwdata[0];
        default:        ae_en <= ae_en;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame-boundary shadows
  // ---------------------------------------------------------------
  // a frame never mixes old and new geometry or timing
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_window6    <= '0;
      o_timing     <= '0;
      exp_applied  <= RST_EXP_TIME;
      mode_applied <= EXP_OFF;
    end else if (i_frame_start) begin
      o_window6    <= win;
      o_timing     <= tim;
      exp_applied  <= next_exp;
      mode_applied <= exp_mode;
    end
  end

  // auto loop request clamped so it never passes the limit
  always_comb begin
    next_exp = exp_time;
    if (ae_en) begin
      next_exp = (i_ae_exposure_req > max_exp) ?
                 max_exp : i_ae_exposure_req;
    end
  end

  // ---------------------------------------------------------------
  // auto loop controls
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ae_enable    <= 1'b0;
      o_ag_enable    <= 1'b0;
      o_ae_step_mult <= 3'h1;
      o_ag_step_mult <= 3'h1;
      o_luma_target  <= RST_LUMA_TGT;
      o_gain_applied <= 10'h000;
    end else begin
      o_ae_enable    <= ae_en;
      o_ag_enable    <= ag_en;
      o_ae_step_mult <= {1'b0, ae_speed} + 3'h1;
      o_ag_step_mult <= {1'b0, ag_speed} + 3'h1;
      o_luma_target  <= luma_tgt;
      if (ag_en) begin
        o_gain_applied <= (i_ag_gain_req > max_gain) ?
                          max_gain : i_ag_gain_req;
      end
    end
  end

  // ---------------------------------------------------------------
  // microsecond enable
  // ---------------------------------------------------------------
  // restarts at each frame so the first exposure microsecond is whole
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_frame_start) begin
      us_cnt  <= 5'h00;
      us_tick <= 1'b0;
    end else if (us_cnt == 5'(US_CYCLES - 1)) begin
      us_cnt  <= 5'h00;
      us_tick <= 1'b1;
    end else begin
      us_cnt  <= us_cnt + 5'h01;
      us_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
    end else begin
      trig_s1 <= i_trigger;
      trig_s2 <= trig_s1;
      ext_s1  <= i_ext_exposure;
      ext_s2  <= ext_s1;
    end
  end

  // ---------------------------------------------------------------
  // exposure gate
  // ---------------------------------------------------------------
  // internal timer starts at the frame boundary; granularity 1 us
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      exp_cnt <= 24'h000000;
    end else if (i_frame_start) begin
      exp_cnt <= next_exp;
    end else if (us_tick && exp_cnt != 24'h000000) begin
      exp_cnt <= exp_cnt - 24'h000001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_exposure_active <= 1'b0;
    end else begin
      case (mode_applied)
        EXP_OFF:      o_exposure_active <= 1'b0;
        EXP_PULSE:    o_exposure_active <= trig_s2;
        EXP_INTERNAL: o_exposure_active <= (exp_cnt != 24'h000000);
        EXP_EXTERNAL: o_exposure_active <= ext_s2;
        default:      o_exposure_active <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // line stretch
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      line_cnt <= 13'h0000;
    end else if (i_line_start) begin
      line_cnt <= 13'h0000;
    end else if (i_pixel_tick && line_cnt != 13'h1FFF) begin
      line_cnt <= line_cnt + 13'h0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_line_hold <= 1'b0;
    end else begin
      o_line_hold <= o_timing.line_ext &&
                     (line_cnt < o_timing.line_time);
    end
  end

  // ---------------------------------------------------------------
  // frame stretch
  // ---------------------------------------------------------------
  // 24-bit microsecond count reaches about 16.7 s
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      frame_cnt <= 24'h000000;
    end else if (i_frame_start) begin
      frame_cnt <= 24'h000000;
    end else if (us_tick && frame_cnt != 24'hFFFFFF) begin
      frame_cnt <= frame_cnt + 24'h000001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_frame_hold <= 1'b0;
    end else begin
      o_frame_hold <= o_timing.frame_ext &&
                      (frame_cnt < o_timing.frame_time);
    end
  end

endmodule

// >>> bench/etac_regs_props.sv
// property checker for the exposure and timing register bank
`timescale 1ns/1ns
module etac_regs_props
  import etac_pkg::*;
(
  // clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  // bus, frame and gain request inputs
  input wire logic                i_hsel,
  input wire logic [1:0]          i_htrans,
  input wire logic                i_hwrite,
  input wire logic                i_hready,
  input wire logic                i_frame_start,
  input wire logic [GAIN_W-1:0]   i_ag_gain_req,
  // design outputs
  input wire logic                o_hreadyout,
  input wire logic                o_hresp,
  input wire etac_window_t        o_window6,
  input wire etac_timing_t        o_timing,
  input wire logic                o_line_hold,
  input wire logic                o_frame_hold,
  input wire logic                o_ag_enable,
  input wire logic [2:0]          o_ae_step_mult,
  input wire logic [2:0]          o_ag_step_mult,
  input wire logic [GAIN_W-1:0]   o_gain_applied
);
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_take;
    i_hsel && i_htrans[1] && i_hready;
  endsequence
  sequence s_rd_answer;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  AST_RD_ONE_WAIT: assert property (
    s_take and !i_hwrite |=> s_rd_answer)
    else $error("read did not answer after one wait");
  AST_WR_NO_WAIT: assert property (s_take and i_hwrite |=> o_hreadyout)
    else $error("write inserted a wait state");
  AST_OKAY_ONLY: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  AST_WIN_AT_FRAME: assert property (
    !$past(i_frame_start) |-> $stable(o_window6))
    else $error("window changed outside frame boundary");
  AST_TIM_AT_FRAME: assert property (
    !$past(i_frame_start) |-> $stable(o_timing))
    else $error("timing changed outside frame boundary");
  AST_LINE_HOLD: assert property (o_line_hold
    |-> o_timing.line_ext || $past(o_timing.line_ext))
    else $error("line held without line stretch");
  AST_FRAME_HOLD: assert property (o_frame_hold
    |-> o_timing.frame_ext || $past(o_timing.frame_ext))
    else $error("frame held without frame stretch");
  AST_AE_MULT: assert property (o_ae_step_mult inside {[3'h1:3'h4]})
    else $error("exposure loop speed out of range");
  AST_AG_MULT: assert property (o_ag_step_mult inside {[3'h1:3'h4]})
    else $error("gain loop speed out of range");
  AST_GAIN_CLAMP: assert property (o_ag_enable && $past(o_ag_enable)
    |-> o_gain_applied <= $past(i_ag_gain_req))
    else $error("applied gain above request");
  AST_GAIN_HOLD: assert property (!o_ag_enable && !$past(o_ag_enable)
    |-> $stable(o_gain_applied))
    else $error("gain moved with gain loop off");
endmodule

bind etac_regs etac_regs_props u_props (.*);

// >>> bench/tb_etac_regs.sv
// self-checking bench for the exposure and timing register bank
`timescale 1ns/1ns
module tb_etac_regs;
  import etac_pkg::*;
  logic               clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, rd_data;
  logic [1:0]         htrans = 2'b00;
  logic               fs = 1'b0, ls = 1'b0, pt = 1'b0, trig = 1'b0;
  logic               ext = 1'b0, hrdy, hresp, gate, lhold, fhold;
  logic               aeen, agen;
  logic [TIME_W-1:0]  ae_req = 24'h000009;
  logic [GAIN_W-1:0]  ag_req = 10'h000, gain;
  logic [2:0]         aem, agm;
  logic [WIN_W-1:0]   luma;
  etac_window_t       win;
  etac_timing_t       tim;
  int                 miscompares = 0, tests_run = 0, cyc = 0, n;
  logic [11:0] ofs [22] = '{12'h150, 12'h154, 12'h158, 12'h160, 12'h174,
    12'h178, 12'h200, 12'h240, 12'h260, 12'h280, 12'h2A0, 12'h544, 12'h548,
    12'h54C, 12'h550, 12'h554, 12'h558, 12'h5A8, 12'h5AC, 12'h5B0, 12'h608,
    12'h700};
  logic [31:0] msk [22] = '{32'h1, 32'h1, 32'hFFF, 32'h3FF, 32'h3, 32'h3,
    32'h1, 32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'h3, 32'hFFFFFF, 32'h1,
    32'h1, 32'h1FFF, 32'hFFFFFF, 32'h1, 32'h1, 32'hFFFFFF, 32'h1, 32'h0};

  initial forever #20 clk = ~clk;

  etac_regs DUT (
    .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(rd_data),
    .i_frame_start(fs), .i_line_start(ls), .i_pixel_tick(pt),
    .i_trigger(trig), .i_ext_exposure(ext), .i_ae_exposure_req(ae_req),
    .i_ag_gain_req(ag_req), .o_window6(win), .o_timing(tim),
    .o_exposure_active(gate), .o_line_hold(lhold), .o_frame_hold(fhold),
    .o_ae_enable(aeen), .o_ag_enable(agen), .o_ae_step_mult(aem),
    .o_ag_step_mult(agm), .o_luma_target(luma), .o_gain_applied(gain));

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic addr_ph(input logic [11:0] a, input logic w);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    addr_ph(a, 1'b0);
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    chk($sformatf("reg %h", a), 48'(rd_data), 48'(e));
  endtask

  function automatic logic [31:0] rst_of(input logic [11:0] a);
    case (a)
      12'h158: return 32'(RST_LUMA_TGT);
      12'h160: return 32'(RST_MAX_GAIN);
      12'h548: return 32'(RST_EXP_TIME);
      12'h5B0: return 32'(RST_MAX_EXP);
      default: return 32'h0;
    endcase
  endfunction

  // shadows load on the pulse edge, so return one edge later
  task automatic frame();
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 22; i++) begin
      rchk(ofs[i], rst_of(ofs[i]));
      wr(ofs[i], 32'hFFFFFFFF);
      rchk(ofs[i], msk[i]);
    end
    chk("timing_early", 48'(tim), 48'h0);
    chk("luma", 48'(luma), 48'hFFF);
    chk("loops_on", 48'({aeen, agen}), 48'h3);
    frame();
    chk("timing", 48'(tim), 48'({6'h3F, 13'h1FFF, 24'hFFFFFF}));
    chk("window", 48'(win), 48'hFFFFFFFFFFFF);
    for (int k = 0; k < 4; k++) begin
      wr(12'h174, 32'(k));
      wr(12'h178, 32'(3 - k));
      rchk(12'h178, 32'(3 - k));
      chk("ae_mult", 48'(aem), 48'(k + 1));
      chk("ag_mult", 48'(agm), 48'(4 - k));
    end
    // zero internal time makes mode two dark, so only pin modes light up
    wr(12'h150, 32'h0);
    wr(12'h548, 32'h0);
    trig <= 1'b1;
    ext  <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(12'h544, 32'(m));
      frame();
      repeat (6) @(posedge clk);
      chk("gate_mode", 48'(gate), 48'(m == 1 || m == 3));
    end
    ext <= 1'b0;
    repeat (6) @(posedge clk);
    chk("gate_ext_off", 48'(gate), 48'h0);
    wr(12'h544, 32'h2);
    wr(12'h548, 32'h2);
    wr(12'h558, 32'h3);
    frame();
    n = 0;
    for (int k = 0; k < 150; k++) begin
      @(posedge clk);
      n += int'(gate === 1'b1);
      if (k == 10) chk("fhold_on", 48'(fhold), 48'h1);
    end
    chk("fhold_off", 48'(fhold), 48'h0);
    chk("exp_len", 48'(n >= 48 && n <= 52), 48'h1);
    wr(12'h150, 32'h1);
    wr(12'h5B0, 32'h5);
    frame();
    rchk(12'h614, 32'h5);
    ae_req <= 24'h000003;
    frame();
    rchk(12'h614, 32'h3);
    wr(12'h160, 32'h100);
    ag_req <= 10'h200;
    repeat (4) @(posedge clk);
    chk("gain_clamp", 48'(gain), 48'h100);
    ag_req <= 10'h050;
    repeat (4) @(posedge clk);
    chk("gain_pass", 48'(gain), 48'h050);
    wr(12'h154, 32'h0);
    ag_req <= 10'h070;
    repeat (4) @(posedge clk);
    chk("gain_held", 48'(gain), 48'h050);
    wr(12'h554, 32'h3);
    frame();
    ls <= 1'b1;
    @(posedge clk);
    ls <= 1'b0;
    repeat (2) @(posedge clk);
    chk("lhold_on", 48'(lhold), 48'h1);
    pt <= 1'b1;
    repeat (6) @(posedge clk);
    pt <= 1'b0;
    repeat (3) @(posedge clk);
    chk("lhold_off", 48'(lhold), 48'h0);
    wrap_up();
  end
endmodule
